// ### src/rxcsc_ctrl.sv
`timescale 1ns/1ps
module rxcsc_ctrl #(
  parameter int unsigned DIVA = rxcsc_pkg::DIV_A,
  parameter int unsigned DIVB = rxcsc_pkg::DIV_B,
  parameter int unsigned DIVC = rxcsc_pkg::DIV_C
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Mode pins
  input  wire logic                        enable,
  input  wire logic                        rx_activate,
  // Oscillator and supply status
  input  wire logic                        amplitude_ok,
  input  wire logic                        digital_supply_ok,
  // Clock and rate select pins
  input  wire logic                        clkdiv_select_lo,
  input  wire logic                        clkdiv_select_hi,
  input  wire logic                        rate_range_bit0,
  input  wire logic                        rate_range_bit1,
  // Sensitivity and data
  input  wire logic                        sense_reduce_sel,
  input  wire logic                        rssi_above_threshold,
  input  wire logic                        modulation_select,
  input  wire logic                        demod_data,
  // Register port
  input  wire logic [rxcsc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // Status and outputs
  output logic                             osc_run,
  output logic                             xto_ok,
  output logic                             rx_path_en,
  output logic                             rx_ready,
  output logic                             mcu_clk,
  output logic                             base_tick,
  output logic                             scaled_tick,
  output logic                             full_sensitivity,
  output logic                             data_out
);
  import rxcsc_pkg::*;

  // Mode and oscillator release
  logic         xok_q;
  logic         xok_d;
  logic         rel_q;
  logic         rel_d;
  logic         osc_on;

  assign osc_on = enable | rx_activate;

  always_comb
  begin
    xok_d = osc_on & amplitude_ok;
    rel_d = xok_q & digital_supply_ok & osc_on;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      xok_q <= 1'b0;
      rel_q <= 1'b0;
    end
    else
    begin
      xok_q <= xok_d;
      rel_q <= rel_d;
    end
  end

  // Controller clock divider
  logic [1:0]       pin_sel;
  logic [1:0]       sel_q;
  logic [1:0]       sel_d;
  logic [DIV_W-1:0] div_n;
  logic [DIV_W-1:0] half_n;
  logic [DIV_W-1:0] dcnt_q;
  logic [DIV_W-1:0] dcnt_d;
  logic             hi_q;
  logic             hi_d;
  logic             neg_q;

  assign pin_sel = {clkdiv_select_hi, clkdiv_select_lo};

  always_comb
  begin
    case (sel_q)
      CLKSEL_DIV3:  div_n = DIV_W'(DIVA);
      CLKSEL_DIV6:  div_n = DIV_W'(DIVB);
      CLKSEL_DIV12: div_n = DIV_W'(DIVC);
      default:      div_n = DIV_W'(1);
    endcase
  end

  // Selection only moves at a period boundary so no runt pulse escapes
  always_comb
  begin
    sel_d  = sel_q;
    dcnt_d = dcnt_q + 1'b1;
    if (sel_q == CLKSEL_OFF || dcnt_q >= div_n - 1'b1)
    begin
      dcnt_d = '0;
      sel_d  = rel_q ? pin_sel : CLKSEL_OFF;
    end
    // High half follows the divisor being entered, so a start from off
    // gives a full-width first pulse
    case (sel_d)
      CLKSEL_DIV3:  half_n = DIV_W'(DIVA / 2);
      CLKSEL_DIV6:  half_n = DIV_W'(DIVB / 2);
      CLKSEL_DIV12: half_n = DIV_W'(DIVC / 2);
      default:      half_n = '0;
    endcase
    if (sel_d == CLKSEL_OFF)
      hi_d = 1'b0;
    else
      hi_d = (dcnt_d < half_n);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sel_q  <= CLKSEL_OFF;
      dcnt_q <= '0;
      hi_q   <= 1'b0;
    end
    else
    begin
      sel_q  <= sel_d;
      dcnt_q <= dcnt_d;
      hi_q   <= hi_d;
    end
  end

  // Half-cycle stretch makes the odd divisor symmetric
  always_ff @(negedge clk_sys or posedge rst)
  begin
    if (rst)
      neg_q <= 1'b0;
    else
      neg_q <= hi_q;
  end

  assign mcu_clk = hi_q | (neg_q & (sel_q == CLKSEL_DIV3));

  // Base and scaled ticks
  logic [1:0]       rate_range;
  logic [2:0]       scale_lim;
  logic             btick;
  logic             stick;

  assign rate_range = {rate_range_bit1, rate_range_bit0};

  always_comb
  begin
    case (rate_range)
      2'h0:    scale_lim = 3'(SCALE_R0 - 1);
      2'h1:    scale_lim = 3'(SCALE_R1 - 1);
      2'h2:    scale_lim = 3'(SCALE_R2 - 1);
      default: scale_lim = 3'(SCALE_R3 - 1);
    endcase
  end

  rxcsc_tick_div #(.W(4)) u_base (
    .clk_sys (clk_sys),
    .rst     (rst),
    .en      (osc_on),
    .limit   (4'(BASE_DIV - 1)),
    .tick    (btick)
  );

  rxcsc_tick_div #(.W(3)) u_scaled (
    .clk_sys (clk_sys),
    .rst     (rst),
    .en      (btick),
    .limit   (scale_lim),
    .tick    (stick)
  );

  // Config register
  logic [CFG_DEB_W-1:0] deb_len_q;
  logic [CFG_DEB_W-1:0] deb_len_d;
  logic [CFG_SU_W-1:0]  su_len_q;
  logic [CFG_SU_W-1:0]  su_len_d;
  logic                 soft_clr;
  logic                 cfg_wr;

  assign cfg_wr   = reg_wr && (reg_addr == OFF_CFG);
  assign soft_clr = cfg_wr && reg_wdata[CFG_CLR_BIT];

  always_comb
  begin
    deb_len_d = deb_len_q;
    su_len_d  = su_len_q;
    if (cfg_wr)
    begin
      deb_len_d = reg_wdata[CFG_DEB_LSB +: CFG_DEB_W];
      su_len_d  = reg_wdata[CFG_SU_LSB +: CFG_SU_W];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      deb_len_q <= CFG_DEB_RST;
      su_len_q  <= CFG_SU_RST;
    end
    else
    begin
      deb_len_q <= deb_len_d;
      su_len_q  <= su_len_d;
    end
  end

  // Receive path sequencing
  rxcsc_state_t         st_q;
  rxcsc_state_t         st_d;
  logic [CFG_SU_W-1:0]  su_cnt_q;
  logic [CFG_SU_W-1:0]  su_cnt_d;

  always_comb
  begin
    st_d     = st_q;
    su_cnt_d = su_cnt_q;
    case (st_q)
      RXCSC_OFF:
        if (osc_on)
          st_d = RXCSC_STANDBY;
      RXCSC_STANDBY:
      begin
        su_cnt_d = '0;
        if (!osc_on)
          st_d = RXCSC_OFF;
        else if (rx_activate && rel_q)
          st_d = RXCSC_STARTUP;
      end
      RXCSC_STARTUP:
      begin
        if (!rx_activate)
          st_d = osc_on ? RXCSC_STANDBY : RXCSC_OFF;
        else if (su_cnt_q >= su_len_q)
          st_d = RXCSC_READY;
        else if (stick)
          su_cnt_d = su_cnt_q + 1'b1;
      end
      RXCSC_READY:
        if (!rx_activate)
          st_d = osc_on ? RXCSC_STANDBY : RXCSC_OFF;
      default:
        st_d = RXCSC_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q     <= RXCSC_OFF;
      su_cnt_q <= '0;
    end
    else
    begin
      st_q     <= st_d;
      su_cnt_q <= su_cnt_d;
    end
  end

  // Data debounce in scaled ticks
  logic                 deb_q;
  logic                 deb_d;
  logic [CFG_DEB_W-1:0] dcn_q;
  logic [CFG_DEB_W-1:0] dcn_d;

  always_comb
  begin
    deb_d = deb_q;
    dcn_d = dcn_q;
    if (demod_data == deb_q)
      dcn_d = '0;
    else if (dcn_q >= deb_len_q)
    begin
      deb_d = demod_data;
      dcn_d = '0;
    end
    else if (stick)
      dcn_d = dcn_q + 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      deb_q <= 1'b0;
      dcn_q <= '0;
    end
    else
    begin
      deb_q <= deb_d;
      dcn_q <= dcn_d;
    end
  end

  // Sensitivity gating latch; same path for either demodulation mode
  logic lat_q;
  logic lat_d;
  logic mod_q;
  logic mod_d;
  logic dout_q;
  logic dout_d;

  always_comb
  begin
    mod_d = modulation_select;
    lat_d = lat_q;
    if ((modulation_select && !mod_q) || soft_clr)
      lat_d = 1'b0;
    if (!rx_activate)
      lat_d = 1'b0;
    else if (rssi_above_threshold)
      lat_d = 1'b1;
    if (st_q != RXCSC_READY)
      dout_d = 1'b0;
    else if (!sense_reduce_sel)
      dout_d = deb_q;
    else
      dout_d = deb_q & lat_q;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      lat_q  <= 1'b0;
      mod_q  <= 1'b0;
      dout_q <= 1'b0;
    end
    else
    begin
      lat_q  <= lat_d;
      mod_q  <= mod_d;
      dout_q <= dout_d;
    end
  end

  // Register reads, data one cycle after the strobe
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  always_comb
  begin
    rd_d = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_CFG:
        begin
          rd_d[CFG_DEB_LSB +: CFG_DEB_W] = deb_len_q;
          rd_d[CFG_SU_LSB +: CFG_SU_W]   = su_len_q;
        end
        OFF_STAT:
        begin
          rd_d[ST_OSC]        = osc_on;
          rd_d[ST_XOK]        = xok_q;
          rd_d[ST_REL]        = rel_q;
          rd_d[ST_ACT]        = (st_q == RXCSC_STARTUP) ||
                                (st_q == RXCSC_READY);
          rd_d[ST_RDY]        = (st_q == RXCSC_READY);
          rd_d[ST_LATCH]      = lat_q;
          rd_d[ST_FULL]       = !sense_reduce_sel || lat_q;
          rd_d[ST_RR +: 2]    = rate_range;
          rd_d[ST_SEL +: 2]   = sel_q;
        end
        default:
          rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rd_q <= '0;
    else
      rd_q <= rd_d;
  end

  assign reg_rdata        = rd_q;
  assign osc_run          = osc_on;
  assign xto_ok           = xok_q;
  assign rx_path_en       = (st_q == RXCSC_STARTUP) ||
                            (st_q == RXCSC_READY);
  assign rx_ready         = (st_q == RXCSC_READY);
  assign base_tick        = btick;
  assign scaled_tick      = stick;
  assign full_sensitivity = !sense_reduce_sel || lat_q;
  assign data_out         = dout_q;
endmodule // rxcsc_ctrl

// ### common/rxcsc_pkg.sv
package rxcsc_pkg;
  // Controller clock select codes and divisors
  localparam logic [1:0] CLKSEL_OFF   = 2'h0;
  localparam logic [1:0] CLKSEL_DIV3  = 2'h1;
  localparam logic [1:0] CLKSEL_DIV6  = 2'h2;
  localparam logic [1:0] CLKSEL_DIV12 = 2'h3;
  localparam int unsigned DIV_A = 3;
  localparam int unsigned DIV_B = 6;
  localparam int unsigned DIV_C = 12;
  localparam int unsigned DIV_W = 4;
  // Digital timing base
  localparam int unsigned BASE_DIV = 16;
  localparam int unsigned SCALE_R0 = 8;
  localparam int unsigned SCALE_R1 = 4;
  localparam int unsigned SCALE_R2 = 2;
  localparam int unsigned SCALE_R3 = 1;
  // Register map
  localparam int unsigned ADDR_W  = 4;
  localparam logic [3:0] OFF_CFG  = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  // Config fields and reset values
  localparam int unsigned CFG_DEB_LSB = 0;
  localparam int unsigned CFG_DEB_W   = 4;
  localparam int unsigned CFG_SU_LSB  = 8;
  localparam int unsigned CFG_SU_W    = 8;
  localparam int unsigned CFG_CLR_BIT = 16;
  localparam logic [3:0] CFG_DEB_RST  = 4'h3;
  localparam logic [7:0] CFG_SU_RST   = 8'h20;
  // Status bit positions
  localparam int unsigned ST_OSC   = 0;
  localparam int unsigned ST_XOK   = 1;
  localparam int unsigned ST_REL   = 2;
  localparam int unsigned ST_ACT   = 3;
  localparam int unsigned ST_RDY   = 4;
  localparam int unsigned ST_LATCH = 5;
  localparam int unsigned ST_FULL  = 6;
  localparam int unsigned ST_RR    = 8;
  localparam int unsigned ST_SEL   = 10;
  // Receive path states
  typedef enum logic [3:0] {
    RXCSC_OFF     = 4'h1,
    RXCSC_STANDBY = 4'h2,
    RXCSC_STARTUP = 4'h4,
    RXCSC_READY   = 4'h8
  } rxcsc_state_t;
endpackage

// ### src/rxcsc_tick_div.sv
`timescale 1ns/1ps
module rxcsc_tick_div #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Count control
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  // Tick out
  output logic              tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (en)
    begin
      if (cnt_q >= limit)
      begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // rxcsc_tick_div

// ### verification/rxcsc_ctrl_sva.sv
`timescale 1ns/1ps
module rxcsc_ctrl_sva #(
  parameter int unsigned DIVA = 3,
  parameter int unsigned DIVB = 6,
  parameter int unsigned DIVC = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins
  input wire logic enable,
  input wire logic rx_activate,
  input wire logic amplitude_ok,
  input wire logic digital_supply_ok,
  input wire logic clkdiv_select_lo,
  input wire logic clkdiv_select_hi,
  input wire logic rate_range_bit0,
  input wire logic rate_range_bit1,
  input wire logic sense_reduce_sel,
  input wire logic rssi_above_threshold,
  input wire logic modulation_select,
  // Outputs
  input wire logic osc_run,
  input wire logic xto_ok,
  input wire logic mcu_clk,
  input wire logic base_tick,
  input wire logic scaled_tick,
  input wire logic full_sensitivity,
  input wire logic data_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] off_q, bgap_q, sgap_q;
  logic       bseen_q, sseen_q;
  logic [1:0] rr_q;
  wire  [1:0] rr = {rate_range_bit1, rate_range_bit0};
  wire        sel12 = clkdiv_select_lo & clkdiv_select_hi;
  wire        stop = !(clkdiv_select_lo | clkdiv_select_hi) | !xto_ok
                     | !digital_supply_ok;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      {off_q, bgap_q, sgap_q} <= 24'h0;
      {bseen_q, sseen_q, rr_q} <= 4'h0;
    end
    else
    begin
      // Saturates so a long stop never wraps back under the limit
      off_q   <= !stop ? 8'h0 : off_q + {7'h0, off_q != 8'hff};
      bgap_q  <= base_tick ? 8'h0 : bgap_q + 8'h1;
      sgap_q  <= scaled_tick ? 8'h0 : sgap_q + 8'h1;
      bseen_q <= osc_run & (base_tick | bseen_q);
      // A range change restarts the scaled measurement
      sseen_q <= osc_run & (rr == rr_q) & (scaled_tick | sseen_q);
      rr_q    <= rr;
    end
  end

  AST_CLK_HELD:
    assert property (off_q >= 8'd16 |-> !mcu_clk) else $error("clk not low");
  AST_XTO:
    assert property (!amplitude_ok |=> !xto_ok) else $error("xto early");
  AST_OFF:
    assert property (!enable && !rx_activate |-> !osc_run ##1 !xto_ok)
    else $error("off mode runs");
  AST_BASE:
    assert property (base_tick && bseen_q |-> bgap_q == 8'd15)
    else $error("base tick period");
  AST_SCALE:
    // A tick seen just after a range change was timed by the old range
    assert property (scaled_tick && sseen_q
      |-> sgap_q == (8'h80 >> rr_q) - 8'h1)
    else $error("scaled tick period");
  AST_DUTY:
    assert property ((sel12 && !stop)[*3] ##0 $rose(mcu_clk)
      |-> mcu_clk[*6] ##1 !mcu_clk[*6]) else $error("clk duty");
  AST_FULL:
    assert property (!sense_reduce_sel |-> full_sensitivity)
    else $error("full sens");
  AST_GATE:
    assert property ((sense_reduce_sel && !full_sensitivity)[*4] |-> !data_out)
    else $error("data not gated");
  AST_CLR:
    assert property ($rose(modulation_select) ##0 (sense_reduce_sel
      && rx_activate && !rssi_above_threshold)[*3] |-> !full_sensitivity)
    else $error("latch not cleared");
  AST_RXCLR:
    assert property ((!rx_activate && sense_reduce_sel)[*2] |-> !full_sensitivity)
    else $error("latch kept");
endmodule // rxcsc_ctrl_sva

bind rxcsc_ctrl rxcsc_ctrl_sva #(.DIVA(DIVA), .DIVB(DIVB), .DIVC(DIVC)) u_sva (.*);

// ### verification/rxcsc_mcu.sv
`timescale 1ns/1ps
module rxcsc_mcu (
  // Clock from the receiver
  input  wire logic clk_sys,
  input  wire logic mcu_clk,
  // Control pins
  output logic      enable,
  output logic      rx_activate,
  output logic      clkdiv_select_lo,
  output logic      clkdiv_select_hi,
  output logic      rate_range_bit0,
  output logic      rate_range_bit1,
  output logic      sense_reduce_sel,
  output logic      modulation_select
);
  initial
  begin
    {enable, rx_activate, clkdiv_select_lo, clkdiv_select_hi} = 4'h0;
    {rate_range_bit0, rate_range_bit1} = 2'h0;
    {sense_reduce_sel, modulation_select} = 2'h0;
  end

  // Reduction select settles a cycle before receive-activate moves
  task automatic pins(input logic en, input logic rx, input logic sr);
    @(posedge clk_sys);
    enable <= en;
    sense_reduce_sel <= sr;
    @(posedge clk_sys);
    rx_activate <= rx;
  endtask
  task automatic sel(input logic [1:0] v);
    @(posedge clk_sys);
    {clkdiv_select_hi, clkdiv_select_lo} <= v;
  endtask
  task automatic rate(input logic [1:0] v);
    @(posedge clk_sys);
    {rate_range_bit1, rate_range_bit0} <= v;
  endtask
  task automatic mode(input logic m);
    @(posedge clk_sys);
    modulation_select <= m;
  endtask
  // One cycle is the shortest pulse the receiver has to honour
  task automatic pulse();
    mode(1'b1);
    mode(1'b0);
  endtask
  task automatic measure(output int per, output int hi);
    realtime t0;
    @(posedge mcu_clk);
    t0 = $realtime;
    @(negedge mcu_clk);
    hi = int'($realtime - t0);
    @(posedge mcu_clk);
    per = int'($realtime - t0);
  endtask
endmodule // rxcsc_mcu

// ### verification/rxcsc_ctrl_test.sv
`timescale 1ns/1ps
module rxcsc_ctrl_test;
  import rxcsc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        amplitude_ok = 1'b0;
  logic        digital_supply_ok = 1'b0;
  logic        rssi_above_threshold = 1'b0;
  logic        demod_data = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, rv;
  logic        enable, rx_activate, clkdiv_select_lo, clkdiv_select_hi;
  logic        rate_range_bit0, rate_range_bit1, sense_reduce_sel;
  logic        modulation_select, osc_run, xto_ok, rx_path_en, rx_ready;
  logic        mcu_clk, base_tick, scaled_tick, full_sensitivity, data_out;
  int          n_errors = 0;
  int          check_count = 0;
  int          per, hi, g;

  always #5 clk_sys = ~clk_sys;

  rxcsc_mcu u_mcu (.*);
  rxcsc_ctrl dut (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask
  // Cycles between two pulses; a hang here is cut by the watchdog
  task automatic gap(input logic sc);
    g = 0;
    do @(negedge clk_sys); while ((sc ? scaled_tick : base_tick) !== 1'b1);
    do
    begin
      @(negedge clk_sys);
      g++;
    end
    while ((sc ? scaled_tick : base_tick) !== 1'b1);
  endtask

  task automatic t_regs();
    rd(OFF_CFG);
    chk(rv, {16'h0, CFG_SU_RST, 4'h0, CFG_DEB_RST});
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc);
    chk(rv, 32'h0);
    // A debounce and start-up of one keep the run brief
    wr(OFF_CFG, 32'h0101);
    rd(OFF_CFG);
    chk(rv, 32'h0101);
  endtask

  task automatic t_clock();
    int dv[4] = '{0, DIV_A, DIV_B, DIV_C};
    @(posedge clk_sys);
    digital_supply_ok <= 1'b1;
    u_mcu.pins(1'b1, 1'b0, 1'b0);
    u_mcu.sel(CLKSEL_DIV3);
    cyc(40);
    chk(32'(mcu_clk), 32'h0);
    rd(OFF_STAT);
    chk(rv, 32'h41);
    @(posedge clk_sys);
    amplitude_ok <= 1'b1;
    for (int i = 1; i < 4; i++)
    begin
      u_mcu.sel(2'(i));
      cyc(40);
      u_mcu.measure(per, hi);
      chk(32'(per), 32'(10 * dv[i]));
      chk(32'(hi), 32'(5 * dv[i]));
    end
    rd(OFF_STAT);
    chk(rv, 32'h0c47);
    @(posedge clk_sys);
    digital_supply_ok <= 1'b0;
    cyc(30);
    chk(32'(mcu_clk), 32'h0);
    rd(OFF_STAT);
    chk(rv, 32'h43);
    @(posedge clk_sys);
    digital_supply_ok <= 1'b1;
    u_mcu.sel(CLKSEL_OFF);
    cyc(30);
    chk(32'(mcu_clk), 32'h0);
  endtask

  task automatic t_ticks();
    for (int r = 0; r < 4; r++)
    begin
      u_mcu.rate(2'(r));
      gap(1'b1);
      gap(1'b1);
      chk(32'(g), 32'(BASE_DIV * (SCALE_R0 >> r)));
    end
    gap(1'b0);
    chk(32'(g), 32'(BASE_DIV));
  endtask

  task automatic t_sense();
    @(posedge clk_sys);
    demod_data <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      u_mcu.mode(1'(m));
      u_mcu.pins(1'b1, 1'b0, 1'b1);
      u_mcu.pins(1'b1, 1'b1, 1'b1);
      cyc(2);
      chk(32'({rx_path_en, rx_ready}), 32'h2);
      cyc(150);
      chk(32'({data_out, full_sensitivity}), 32'h0);
      chk(32'({rx_path_en, rx_ready}), 32'h3);
      @(posedge clk_sys);
      rssi_above_threshold <= 1'b1;
      @(posedge clk_sys);
      rssi_above_threshold <= 1'b0;
      cyc(150);
      chk(32'({data_out, full_sensitivity}), 32'h3);
      if (m == 0)
        u_mcu.pulse();
      else
        u_mcu.pins(1'b1, 1'b0, 1'b1);
      cyc(10);
      chk(32'({data_out, full_sensitivity}), 32'h0);
    end
    u_mcu.pins(1'b1, 1'b1, 1'b0);
    cyc(150);
    chk(32'({data_out, full_sensitivity}), 32'h3);
    // A one-cycle dip is shorter than the debounce and must not pass
    @(posedge clk_sys);
    demod_data <= 1'b0;
    @(posedge clk_sys);
    demod_data <= 1'b1;
    cyc(4);
    chk(32'(data_out), 32'h1);
    @(posedge clk_sys);
    demod_data <= 1'b0;
    cyc(60);
    chk(32'(data_out), 32'h0);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_clock();
    t_ticks();
    t_sense();
    test_done();
  end

  initial
  begin
    // The tests need a few thousand cycles
    #200000;
    n_errors++;
    test_done();
  end
endmodule // rxcsc_ctrl_test
